//--- pgcc_clock_config.sv
// Purpose: Pin clock source selection and PLL factor registers
// Assumes: Register port synchronous to sys_clk; pins already in this domain
// Notes: Outputs are registered; one cycle read latency
//
// How it works
// - Bits 6-4 pick pump clock pin: 011 pin zero, 101 pin two, else mute.
// - Bits 2-0 pick oversample clock pin: 011 pin zero, 101 pin two, else mute.
// - Reference pin field: 011 pin zero, 101 pin two, others mute reference.
// - Pin fields matter only while a general pin is the chosen source.
// - P code n divides by n+1, 0 to 14; reset zero.
// - J field is integer 1..63, reset value 8.
// - PLL multiplies pre-divided reference by J.D times R.
// - P, J, D ignored while automatic clock setup is active.
// - Upper and lower D fields form decimal 0..9999; higher never written.
// - Lower eight D bits live in their own register.
// - R code n gives factor n+1, 1 to 16.
`default_nettype none
`include "pgcc_cfg.svh"
module pgcc_clock_config (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Register port
    input wire pgcc_pkg::pgcc_req_t req,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // Mode inputs
    input wire logic auto_setup,
    input wire logic pump_src_is_pin,
    input wire logic osr_src_is_pin,
    input wire logic ref_src_is_pin,
    // Pins
    input wire logic general_pin_zero,
    input wire logic general_pin_two,
    // Clock outputs
    output logic pump_clock_pin,
    output logic oversample_clock_pin,
    output logic pll_reference_pin,
    // PLL factors
    output var pgcc_pkg::pgcc_pll_t pll_cfg
);
    import pgcc_pkg::*;

    logic [7:0] mem_rd;
    logic [55:0] regs;
    logic [2:0] wr_idx;
    logic [2:0] rd_idx;
    logic wr_hit;
    logic rd_pend;

    function automatic logic [2:0] addr_idx(input logic [7:0] a);
        case (a)
            `PGCC_ADDR_PIN_SRC: addr_idx = 3'h0;
            `PGCC_ADDR_PLL_REF: addr_idx = 3'h1;
            `PGCC_ADDR_PRE_DIV: addr_idx = 3'h2;
            `PGCC_ADDR_INT_MUL: addr_idx = 3'h3;
            `PGCC_ADDR_FRAC_UP: addr_idx = 3'h4;
            `PGCC_ADDR_FRAC_LO: addr_idx = 3'h5;
            `PGCC_ADDR_FINAL_R: addr_idx = 3'h6;
            default: addr_idx = 3'h7;
        endcase
    endfunction

    // Shared decode of a 3-bit pin code
    function automatic pgcc_src_t pin_code(input logic [2:0] c);
        case (c)
            `PGCC_SEL_PIN_ZERO: pin_code = PGCC_SRC_PIN_ZERO;
            `PGCC_SEL_PIN_TWO: pin_code = PGCC_SRC_PIN_TWO;
            default: pin_code = PGCC_SRC_MUTE;
        endcase
    endfunction

    function automatic logic pick(input pgcc_src_t s, input logic z, input logic t);
        case (s)
            PGCC_SRC_PIN_ZERO: pick = z;
            PGCC_SRC_PIN_TWO: pick = t;
            default: pick = 1'b0;
        endcase
    endfunction

    // ----------------------------------------
    // Register store
    // ----------------------------------------
    assign wr_idx = addr_idx(req.addr);
    assign rd_idx = addr_idx(req.addr);
    assign wr_hit = req.wr && (wr_idx != 3'h7);

    // Full bytes stored, reserved bits included
    pgcc_reg_mem #(.N(7)) u_mem (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .wr_en(wr_hit),
        .wr_idx(wr_idx),
        .wr_data(req.wdata),
        .rd_idx(rd_idx),
        .rd_data(mem_rd),
        .all_data(regs)
    );

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            rd_pend <= 1'b0;
        else if (clk_en)
            rd_pend <= req.rd;
    end

    always_comb
    begin
        rd_data = mem_rd;
        rd_valid = rd_pend;
    end

    // ----------------------------------------
    // Pin clock selection
    // ----------------------------------------
    pgcc_src_t pump_sel;
    pgcc_src_t osr_sel;
    pgcc_src_t ref_sel;

    always_comb
    begin
        pump_sel = pin_code(regs[`PGCC_PUMP_MSB:`PGCC_PUMP_LSB]);
        osr_sel = pin_code(regs[`PGCC_OSR_MSB:`PGCC_OSR_LSB]);
        ref_sel = pin_code(regs[8 +: 3]);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            pump_clock_pin <= 1'b0;
            oversample_clock_pin <= 1'b0;
            pll_reference_pin <= 1'b0;
        end
        else if (clk_en)
        begin
            // Muted unless a pin is the chosen source
            pump_clock_pin <= pump_src_is_pin
                && pick(pump_sel, general_pin_zero, general_pin_two);
            oversample_clock_pin <= osr_src_is_pin
                && pick(osr_sel, general_pin_zero, general_pin_two);
            pll_reference_pin <= ref_src_is_pin
                && pick(ref_sel, general_pin_zero, general_pin_two);
        end
    end

    // ----------------------------------------
    // PLL factors
    // ----------------------------------------
    logic [13:0] frac_raw;
    assign frac_raw = {regs[32 +: 6], regs[40 +: 8]};

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            pll_cfg.pre_div <= 4'h1;
            pll_cfg.int_mul <= 6'h08;
            pll_cfg.frac <= 14'h0000;
            pll_cfg.final_mul <= 5'h01;
            pll_cfg.valid <= 1'b0;
        end
        else if (clk_en)
        begin
            pll_cfg.pre_div <= regs[16 +: 4] + 4'h1;
            pll_cfg.int_mul <= regs[24 +: 6];
            // Out-of-range D clipped, software keeps it legal
            pll_cfg.frac <= (frac_raw > `PGCC_FRAC_MAX) ? `PGCC_FRAC_MAX : frac_raw;
            pll_cfg.final_mul <= {1'b0, regs[48 +: 4]} + 5'h01;
            // Manual factors only outside auto setup J zero forbidden
            pll_cfg.valid <= !auto_setup && (regs[24 +: 6] != 6'h00);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_pre_div;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en ##1 clk_en |-> pll_cfg.pre_div == $past(regs[16 +: 4], 1) + 4'h1;
    endproperty
    a_pre_div: assert property (p_pre_div) else $error("P divide wrong");

    property p_pump_mute;
        @(posedge sys_clk) disable iff (!rst_b)
        (clk_en && !pump_src_is_pin) |=> !pump_clock_pin;
    endproperty
    a_pump_mute: assert property (p_pump_mute) else $error("Pump not muted");

    property p_pump_zero;
        @(posedge sys_clk) disable iff (!rst_b)
        (clk_en && pump_src_is_pin && regs[6:4] == 3'h3)
            |=> pump_clock_pin == $past(general_pin_zero);
    endproperty
    a_pump_zero: assert property (p_pump_zero) else $error("Pump pin wrong");

    property p_osr_res;
        @(posedge sys_clk) disable iff (!rst_b)
        (clk_en && regs[2:0] == 3'h2) |=> !oversample_clock_pin;
    endproperty
    a_osr_res: assert property (p_osr_res) else $error("OSR not muted");

    property p_ref_two;
        @(posedge sys_clk) disable iff (!rst_b)
        (clk_en && ref_src_is_pin && regs[10:8] == 3'h5)
            |=> pll_reference_pin == $past(general_pin_two);
    endproperty
    a_ref_two: assert property (p_ref_two) else $error("Ref pin wrong");

    property p_auto;
        @(posedge sys_clk) disable iff (!rst_b)
        (clk_en && auto_setup) |=> !pll_cfg.valid;
    endproperty
    a_auto: assert property (p_auto) else $error("Auto mode not honoured");

    property p_int_mul;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en |=> pll_cfg.int_mul == $past(regs[29:24]);
    endproperty
    a_int_mul: assert property (p_int_mul) else $error("J wrong");

    property p_final;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en |=> pll_cfg.final_mul == {1'b0, $past(regs[51:48])} + 5'h01;
    endproperty
    a_final: assert property (p_final) else $error("R wrong");

    property p_frac;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en |=> pll_cfg.frac <= `PGCC_FRAC_MAX;
    endproperty
    a_frac: assert property (p_frac) else $error("D above range");

    property p_frac_pass;
        @(posedge sys_clk) disable iff (!rst_b)
        (clk_en && frac_raw <= `PGCC_FRAC_MAX) |=> pll_cfg.frac == $past(frac_raw);
    endproperty
    a_frac_pass: assert property (p_frac_pass) else $error("D not passed on");
endmodule
`default_nettype wire

//--- pgcc_cfg.svh
// Purpose: Offsets, field positions, reset values for the clock config block
// Assumes: 8-bit register port, byte offsets of the register map
// Notes: Definitions only
`ifndef PGCC_CFG_SVH
`define PGCC_CFG_SVH

`define PGCC_ADDR_PIN_SRC 8'h11
`define PGCC_ADDR_PLL_REF 8'h12
`define PGCC_ADDR_PRE_DIV 8'h14
`define PGCC_ADDR_INT_MUL 8'h15
`define PGCC_ADDR_FRAC_UP 8'h16
`define PGCC_ADDR_FRAC_LO 8'h17
`define PGCC_ADDR_FINAL_R 8'h18

`define PGCC_RST_PIN_SRC 8'h00
`define PGCC_RST_PLL_REF 8'h00
`define PGCC_RST_PRE_DIV 8'h00
`define PGCC_RST_INT_MUL 8'h08
`define PGCC_RST_FRAC_UP 8'h00
`define PGCC_RST_FRAC_LO 8'h00
`define PGCC_RST_FINAL_R 8'h00

`define PGCC_PUMP_MSB 6
`define PGCC_PUMP_LSB 4
`define PGCC_OSR_MSB 2
`define PGCC_OSR_LSB 0

`define PGCC_SEL_PIN_ZERO 3'h3
`define PGCC_SEL_PIN_TWO 3'h5
`define PGCC_FRAC_MAX 14'h270f

`endif

//--- pgcc_pkg.sv
// Purpose: Types shared by the clock config block
// Assumes: Nothing
// Notes: Constants live in pgcc_cfg.svh
`default_nettype none
package pgcc_pkg;
    typedef enum logic [1:0] {PGCC_SRC_MUTE, PGCC_SRC_PIN_ZERO, PGCC_SRC_PIN_TWO} pgcc_src_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pgcc_req_t;

    typedef struct packed {
        logic [3:0] pre_div;
        logic [5:0] int_mul;
        logic [13:0] frac;
        logic [4:0] final_mul;
        logic valid;
    } pgcc_pll_t;
endpackage
`default_nettype wire

//--- pgcc_reg_mem.sv
// Purpose: Small register store for the clock config block
// Assumes: One write and one registered read per cycle
// Notes: Unmapped index reads zero
`default_nettype none
`include "pgcc_cfg.svh"
module pgcc_reg_mem #(
    parameter int N = 7
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Access
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic [2:0] rd_idx,
    output logic [7:0] rd_data,
    // Live contents
    output logic [N*8-1:0] all_data
);
    logic [7:0] mem [N];

    function automatic logic [7:0] rst_val(input int i);
        case (i)
            3: rst_val = `PGCC_RST_INT_MUL;
            default: rst_val = 8'h00;
        endcase
    endfunction

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < N; i++)
                mem[i] <= rst_val(i);
        end
        else if (clk_en && wr_en && int'(wr_idx) < N)
            mem[wr_idx] <= wr_data;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            rd_data <= 8'h00;
        else if (clk_en)
            rd_data <= (int'(rd_idx) < N) ? mem[rd_idx] : 8'h00;
    end

    always_comb
    begin
        for (int i = 0; i < N; i++)
            all_data[i*8 +: 8] = mem[i];
    end
endmodule
`default_nettype wire

//--- pgcc_clock_config_tb.sv
// Purpose: Self-checking bench for the clock config block
// Assumes: One cycle read latency on the register port
// Notes: Inputs driven by non-blocking assignment at sys_clk rise
`default_nettype none
module pgcc_clock_config_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pgcc_pkg::*;
    logic sys_clk;
    logic rst_b;
    logic clk_en;
    pgcc_req_t req;
    logic [7:0] rd_data;
    logic rd_valid;
    logic auto_setup;
    logic [2:0] src_pin;
    logic pin0;
    logic pin2;
    logic pump_o;
    logic osr_o;
    logic ref_o;
    pgcc_pll_t pll_cfg;
    int failures;
    int checked;
    logic [7:0] addrs [7] = '{8'h11, 8'h12, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18};
    logic [7:0] fills [7] = '{8'hbb, 8'hfd, 8'hfe, 8'hff, 8'he7, 8'h0f, 8'hff};
    logic e;

    pgcc_clock_config pgcc_clock_config_inst (
        .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .req(req),
        .rd_data(rd_data), .rd_valid(rd_valid), .auto_setup(auto_setup),
        .pump_src_is_pin(src_pin[0]), .osr_src_is_pin(src_pin[1]),
        .ref_src_is_pin(src_pin[2]), .general_pin_zero(pin0), .general_pin_two(pin2),
        .pump_clock_pin(pump_o), .oversample_clock_pin(osr_o),
        .pll_reference_pin(ref_o), .pll_cfg(pll_cfg)
    );

    task automatic test_done();
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        req <= '0;
    endtask

    // Read and compare; answer waited for under a bound
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        int n;
        @(posedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        req <= '0;
        n = 0;
        #1;
        while (rd_valid !== 1'b1 && n < 4)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n == 4)
        begin
            failures++;
            test_done();
        end
        else
            chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, rd_data});
    endtask

    // Register then output stage land
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk_pll(input logic [15:0] p, input logic [15:0] j, input logic [15:0] d,
                           input logic [15:0] r, input logic v);
        chk("pre_div", p, pll_cfg.pre_div);
        chk("int_mul", j, pll_cfg.int_mul);
        chk("frac", d, pll_cfg.frac);
        chk("final_mul", r, pll_cfg.final_mul);
        chk("valid", v, pll_cfg.valid);
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    initial
    begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        req = '0;
        auto_setup = 1'b0;
        src_pin = 3'b111;
        pin0 = 1'b0;
        pin2 = 1'b0;
        failures = 0;
        checked = 0;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        settle();
        chk_pll(16'h0001, 16'h0008, 16'h0000, 16'h0001, 1'b1);
        for (int i = 0; i < 7; i++)
            rchk(addrs[i], (addrs[i] == 8'h15) ? 8'h08 : 8'h00);
        // Reserved bits set everywhere, top legal codes
        for (int i = 0; i < 7; i++)
            wr(addrs[i], fills[i]);
        for (int i = 0; i < 7; i++)
            rchk(addrs[i], fills[i]);
        settle();
        chk_pll(16'h000f, 16'h003f, 16'h270f, 16'h0010, 1'b1);
        // Every selection code, both pin patterns; osr output not checked for code 101
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h11, {1'b1, c[2:0], 1'b1, c[2:0]});
            wr(8'h12, {5'h1f, c[2:0]});
            for (int p = 0; p < 2; p++)
            begin
                @(posedge sys_clk);
                pin0 <= ~p[0];
                pin2 <= p[0];
                settle();
                e = (c == 3) ? ~p[0] : (c == 5) ? p[0] : 1'b0;
                chk("pump", {15'h0, e}, {15'h0, pump_o});
                chk("ref", {15'h0, e}, {15'h0, ref_o});
                if (c != 5)
                    chk("osr", {15'h0, e}, {15'h0, osr_o});
            end
        end
        // Pin fields without effect unless a pin is the source
        wr(8'h11, 8'h33);
        wr(8'h12, 8'h03);
        pin0 <= 1'b1;
        src_pin <= 3'b000;
        settle();
        chk("pins idle", 16'h0000, {13'h0, pump_o, osr_o, ref_o});
        @(posedge sys_clk);
        src_pin <= 3'b111;
        settle();
        chk("pins live", 16'h0007, {13'h0, pump_o, osr_o, ref_o});
        @(posedge sys_clk);
        auto_setup <= 1'b1;
        settle();
        chk("valid auto", 16'h0000, {15'h0, pll_cfg.valid});
        @(posedge sys_clk);
        auto_setup <= 1'b0;
        // Unmapped address and frozen clock enable
        wr(8'h13, 8'haa);
        rchk(8'h13, 8'h00);
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(8'h15, 8'h05);
        clk_en <= 1'b1;
        rchk(8'h15, 8'hff);
        // Lowest legal P, J and R codes; D of one
        wr(8'h14, 8'h00);
        wr(8'h15, 8'h01);
        wr(8'h16, 8'h00);
        wr(8'h17, 8'h01);
        wr(8'h18, 8'h00);
        settle();
        chk_pll(16'h0001, 16'h0001, 16'h0001, 16'h0001, 1'b1);
        // Second reset in mid-run restores every field
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        settle();
        chk_pll(16'h0001, 16'h0008, 16'h0000, 16'h0001, 1'b1);
        rchk(8'h15, 8'h08);
        rchk(8'h17, 8'h00);
        test_done();
    end
endmodule
`default_nettype wire
